// ==== design/ips_defines.vh ====
// Constants for the peripheral interrupt priority select block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef IPS_DEFINES_VH
`define IPS_DEFINES_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define IPS_ADDR_W 4
`define IPS_OFS_PRIO_ONE 4'h0
`define IPS_OFS_RESET_CTRL 4'h1
`define IPS_OFS_PEND 4'h2
`define IPS_OFS_ENABLE 4'h3
`define IPS_OFS_STATUS 4'h4
`define IPS_OFS_PRIO_TWO 4'h5
// ----------------------------------------
// Field positions
// ----------------------------------------
`define IPS_BIT_CONVERTER 6
`define IPS_BIT_SERIAL_RX 5
`define IPS_BIT_SERIAL_TX 4
`define IPS_BIT_CAPTURE 2
`define IPS_BIT_TIMER2 1
`define IPS_BIT_TIMER1 0
`define IPS_BIT_LEVELS_EN 7
`define IPS_PRIO_MASK 8'h77
`define IPS_PRIO_RESET 8'h77
`define IPS_RESET_CTRL_RESET 8'h00
`define IPS_ZERO_BYTE 8'h00
`endif

// ==== design/ips_prio_reg.v ====
// Priority register with writable mask and unimplemented bits.
// Assumes synchronous active-high reset on the same clock as the writer.
`include "ips_defines.vh"
module ips_prio_reg (
  input wire ref_clk_i,
  input wire reset_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] value_o
);
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      value_o <= `IPS_PRIO_RESET;
    end else if (wr_i) begin
      value_o <= wdata_i & `IPS_PRIO_MASK;
    end
  end
endmodule

// ==== design/ips_steer.v ====
// Per-source steering of requests onto the high or low request line.
// Assumes same-clock pending, enable and priority inputs.
`include "ips_defines.vh"
module ips_steer (
  input wire [7:0] pend_i,
  input wire [7:0] enable_i,
  input wire [7:0] prio_i,
  input wire levels_en_i,
  output wire [7:0] high_o,
  output wire [7:0] low_o
);
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : src
      wire act;
      assign act = pend_i[g] & enable_i[g];
      // Single level mode sends everything high, as the legacy core did
      assign high_o[g] = act & (~levels_en_i | prio_i[g]);
      assign low_o[g] = act & levels_en_i & ~prio_i[g];
    end
  endgenerate
endmodule

// ==== design/ips_top.v ====
// Peripheral interrupt priority select: priority register, level enable,
// pending/enable registers and high/low request steering.
// Assumes a same-clock register port master and external pending event pins.
//
// Notes on behaviour
// - Every peripheral source owns a priority bit, all in the first priority register.
// - Priority bits only matter while the priority levels enable is set.
// - Bit 6 is the converter priority, 1 high and 0 low.
// - Bit 5 is the serial receive priority, 1 high and 0 low.
// - Bit 4 is the serial transmit priority, 1 high and 0 low.
// - Bit 2 is the capture/compare priority, 1 high and 0 low.
// - Bit 1 is the timer-2 match priority, 1 high and 0 low.
// - Bit 0 is the timer-1 overflow priority, 1 high and 0 low.
// - Bits 7 and 3 of the first priority register read as zero.
// - Implemented priority bits reset to 1 on every reset and are read/write.
// - The levels enable is bit 7 of the reset control register, 1 for two levels.
//
// Implementation choices: the register addresses and strobed register access.
`include "ips_defines.vh"
module ips_top (
  input wire ref_clk_i,
  input wire reset_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire converter_evt_i,
  input wire serial_rx_evt_i,
  input wire serial_tx_evt_i,
  input wire capture_evt_i,
  input wire timer2_evt_i,
  input wire timer1_evt_i,
  output reg irq_high_o,
  output reg irq_low_o
);
  // ----------------------------------------
  // Event synchronisers
  // ----------------------------------------
  wire [7:0] evt_raw;
  reg [7:0] evt_meta_r;
  reg [7:0] evt_sync_r;
  reg [7:0] evt_prev_r;
  wire [7:0] evt_rise;
  assign evt_raw = {1'b0, converter_evt_i, serial_rx_evt_i, serial_tx_evt_i,
                    1'b0, capture_evt_i, timer2_evt_i, timer1_evt_i};
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      evt_meta_r <= 8'h00;
      evt_sync_r <= 8'h00;
      evt_prev_r <= 8'h00;
    end else begin
      evt_meta_r <= evt_raw;
      evt_sync_r <= evt_meta_r;
      evt_prev_r <= evt_sync_r;
    end
  end
  assign evt_rise = evt_sync_r & ~evt_prev_r;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  wire [7:0] prio_one;
  wire wr_prio;
  reg [7:0] prio_two_r;
  reg levels_en_r;
  reg [7:0] pend_r;
  reg [7:0] pend_nxt;
  reg [7:0] enable_r;
  assign wr_prio = wr_i && (addr_i == `IPS_OFS_PRIO_ONE);
  ips_prio_reg u_prio (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .wr_i(wr_prio),
    .wdata_i(wdata_i),
    .value_o(prio_one)
  );
  // Second priority register kept as a plain holder for sources not in this block
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      prio_two_r <= 8'hFF;
    end else if (wr_i && (addr_i == `IPS_OFS_PRIO_TWO)) begin
      prio_two_r <= wdata_i;
    end
  end
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      levels_en_r <= 1'b0;
    end else if (wr_i && (addr_i == `IPS_OFS_RESET_CTRL)) begin
      levels_en_r <= wdata_i[`IPS_BIT_LEVELS_EN];
    end
  end
  // Writing 1 clears a pending bit; a new event in the same cycle wins
  always @* begin
    pend_nxt = pend_r;
    if (wr_i && (addr_i == `IPS_OFS_PEND)) begin
      pend_nxt = pend_r & ~wdata_i;
    end
    pend_nxt = (pend_nxt | evt_rise) & `IPS_PRIO_MASK;
  end
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      pend_r <= 8'h00;
      enable_r <= 8'h00;
    end else begin
      pend_r <= pend_nxt;
      if (wr_i && (addr_i == `IPS_OFS_ENABLE)) begin
        enable_r <= wdata_i & `IPS_PRIO_MASK;
      end
    end
  end
  // ----------------------------------------
  // Steering
  // ----------------------------------------
  wire [7:0] high_req;
  wire [7:0] low_req;
  ips_steer u_steer (
    .pend_i(pend_r),
    .enable_i(enable_r),
    .prio_i(prio_one),
    .levels_en_i(levels_en_r),
    .high_o(high_req),
    .low_o(low_req)
  );
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
    end else begin
      irq_high_o <= |high_req;
      irq_low_o <= |low_req;
    end
  end
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire [7:0] prio_view;
  assign prio_view = {1'b0,
                      prio_one[`IPS_BIT_CONVERTER],
                      prio_one[`IPS_BIT_SERIAL_RX],
                      prio_one[`IPS_BIT_SERIAL_TX],
                      1'b0,
                      prio_one[`IPS_BIT_CAPTURE],
                      prio_one[`IPS_BIT_TIMER2],
                      prio_one[`IPS_BIT_TIMER1]};
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o <= `IPS_ZERO_BYTE;
    end else if (rd_i) begin
      if (addr_i == `IPS_OFS_PRIO_ONE) begin
        rdata_o <= prio_view;
      end else if (addr_i == `IPS_OFS_RESET_CTRL) begin
        rdata_o <= {levels_en_r, 7'h00};
      end else if (addr_i == `IPS_OFS_PEND) begin
        rdata_o <= pend_r;
      end else if (addr_i == `IPS_OFS_ENABLE) begin
        rdata_o <= enable_r;
      end else if (addr_i == `IPS_OFS_STATUS) begin
        rdata_o <= {6'h00, irq_low_o, irq_high_o};
      end else if (addr_i == `IPS_OFS_PRIO_TWO) begin
        rdata_o <= prio_two_r;
      end else begin
        rdata_o <= `IPS_ZERO_BYTE;
      end
    end else begin
      // Data stand only in the cycle after the read
      rdata_o <= `IPS_ZERO_BYTE;
    end
  end
endmodule

// ==== verif/ips_chk_sva.sv ====
// Checker for the priority register port and the two request lines.
// Assumes binding to ips_top, one clock, synchronous active-high reset.
module ips_chk (
  input wire ref_clk_i,
  input wire reset_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire irq_high_o,
  input wire irq_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  reg lv_r;
  // Shadow of the levels enable, rebuilt from port writes only
  always @(posedge ref_clk_i) begin
    if (reset_i) lv_r <= 1'b0;
    else if (wr_i && addr_i == 4'h1) lv_r <= wdata_i[7];
  end
  sequence s_wr_rd(a);
    wr_i && addr_i == a ##1 rd_i && addr_i == a;
  endsequence
  chk_prio_rw: assert property (s_wr_rd(4'h0) |=> rdata_o == ($past(wdata_i, 2) & 8'h77))
    else $error("priority readback wrong");
  chk_ctrl_rw: assert property (s_wr_rd(4'h1) |=> rdata_o == {$past(wdata_i[7], 2), 7'h00})
    else $error("levels enable readback wrong");
  chk_rsvd_zero: assert property ($past(rd_i) && $past(addr_i) == 4'h0 |-> !rdata_o[7] && !rdata_o[3])
    else $error("unimplemented bit read as one");
  chk_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  chk_unmapped: assert property ($past(rd_i) && $past(addr_i) > 4'h5 |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_reset_out: assert property ($fell(reset_i) |-> rdata_o == 8'h00 && !irq_high_o && !irq_low_o)
    else $error("outputs active after reset");
  chk_status_mirror: assert property ($past(rd_i) && $past(addr_i) == 4'h4 |->
    rdata_o == {6'h00, $past(irq_low_o), $past(irq_high_o)})
    else $error("status differs from request lines");
  chk_single_level: assert property (!lv_r && !$past(lv_r) |-> !irq_low_o)
    else $error("low request in single level mode");
endmodule

// ==== verif/test_peripheral_irq_priority_select.sv ====
// Self-checking bench for the peripheral interrupt priority select block.
// Assumes ips_top and the checker are compiled alongside.
module test_peripheral_irq_priority_select;
  timeunit 1ns;
  timeprecision 1ns;
  reg ref_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  reg [3:0] addr_i = 4'h0;
  reg [7:0] wdata_i = 8'h00, d;
  reg [5:0] evt = 6'h00;
  wire [7:0] rdata_o;
  wire irq_high_o, irq_low_o;
  int failures = 0, checks_done = 0, k, b;
  reg rd_seen_r = 1'b0;
  reg [7:0] rd_exp_r = 8'h00, rd_want_r = 8'h00;
  ips_top u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .converter_evt_i(evt[5]),
    .serial_rx_evt_i(evt[4]), .serial_tx_evt_i(evt[3]), .capture_evt_i(evt[2]),
    .timer2_evt_i(evt[1]), .timer1_evt_i(evt[0]), .irq_high_o(irq_high_o), .irq_low_o(irq_low_o));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  always #25 ref_clk_i = ~ref_clk_i;
  task chk(input [7:0] got, input [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes stay up between back-to-back calls; idle lowers them
  task wr(input [3:0] a, input [7:0] v);
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= a;
    wdata_i <= v;
    @(posedge ref_clk_i);
  endtask
  task rd(input [3:0] a, input [7:0] e);
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    addr_i <= a;
    rd_exp_r <= e;
    @(posedge ref_clk_i);
  endtask
  task idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Read data stand only in the cycle after the strobe, so look mid-cycle
  always @(posedge ref_clk_i) begin
    rd_seen_r <= rd_i;
    rd_want_r <= rd_exp_r;
  end
  always @(negedge ref_clk_i) begin
    if (rd_seen_r) chk(rdata_o, rd_want_r);
  end
  task wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Only implemented bits survive a write
  function [7:0] prio_exp(input [7:0] v);
    return v & 8'h77;
  endfunction
  // Whole run is about 140 cycles; this leaves ample margin
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
  initial begin
    void'($urandom(9824));
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(4'h0, 8'h77);
    rd(4'h1, 8'h00);
    rd(4'h5, 8'hFF);
    for (k = 0; k < 18; k++) begin
      d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
      wr(4'h0, d);
      rd(4'h0, prio_exp(d));
    end
    rd(4'hF, 8'h00);
    wr(4'h1, 8'hFF);
    rd(4'h1, 8'h80);
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h77);
    for (k = 0; k < 6; k++) begin
      b = (k > 2) ? k + 1 : k;
      wr(4'h0, 8'h77 ^ (8'h01 << b));
      evt[k] <= 1'b1;
      idle(6);
      chk({6'h00, irq_low_o, irq_high_o}, 8'h02);
      rd(4'h4, 8'h02);
      rd(4'h2, 8'h01 << b);
      wr(4'h2, 8'hFF);
      evt[k] <= 1'b0;
      idle(3);
      chk({6'h00, irq_low_o, irq_high_o}, 8'h00);
    end
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    evt[0] <= 1'b1;
    idle(6);
    chk({6'h00, irq_low_o, irq_high_o}, 8'h01);
    wrap_up;
  end
endmodule
bind ips_top ips_chk u_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_high_o(irq_high_o),
  .irq_low_o(irq_low_o));
